// file: hdl/fbss_dict.sv
// parameter dictionary: identity, process data views and mirrored channel parameters
`timescale 1ns/1ns
module fbss_dict
  import fbss_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // request from the mailbox and access enable from the state machine
  input wire logic req_valid,
  input wire fbss_dict_req_type req,
  input wire logic enable,
  // process data views
  input wire logic [15:0] phys_in,
  input wire logic [15:0] pd_out,
  // answer
  output fbss_dict_rsp_type rsp
);

  fbss_dict_rsp_type s_q;
  fbss_dict_rsp_type s_d;
  logic [15:0] chan_mem [0:CHAN_COUNT*CHAN_SUBS-1];
  logic [3:0] area;
  logic chan_hit;
  logic mem_we;
  logic [5:0] addr;

  // full 16-bit index and 8-bit subindex are decoded
  assign area = req.index[15:12];
  // 0x80n0 and its old 0x40n0 twin share one store, so they stay mirrored
  assign chan_hit = (area == AREA_CHAN || area == AREA_LEGACY) && req.index[11:6] == 6'h00
    && req.index[3:0] == 4'h0 && req.sub[7:4] == 4'h0;
  assign addr = {req.index[5:4], req.sub[3:0]};
  assign mem_we = req_valid && enable && chan_hit && req.wr;

  // decode and answer per attribute
  always_comb
  begin
    s_d = '0;
    if (req_valid)
    begin
      s_d.ack = 1'b1;
      if (!enable)
        s_d.abort = 1'b1;
      else if (chan_hit)
        s_d.rdata = req.wr ? req.wdata : chan_mem[addr];
      else if (req.wr && area != AREA_CHAN && area != AREA_LEGACY)
        s_d.abort = 1'b1; // fixed entries refuse writes
      else if (req.index == IDX_DEVTYPE && req.sub == 8'h00)
        s_d.rdata = DEVTYPE_VAL;
      else if (req.index == IDX_IDENTITY && req.sub == 8'h00)
        s_d.rdata = IDENT_COUNT;
      else if (req.index == IDX_IDENTITY && req.sub == 8'h01)
        s_d.rdata = VENDOR_VAL;
      else if (req.index == IDX_IDENTITY && req.sub == 8'h02)
        s_d.rdata = PRODUCT_VAL;
      else if (area == AREA_IN && req.index[11:0] == 12'h000 && req.sub == 8'h01)
        s_d.rdata = phys_in;
      else if (area == AREA_OUT && req.index[11:0] == 12'h000 && req.sub == 8'h01)
        s_d.rdata = pd_out;
      else
        s_d.abort = 1'b1;
    end
  end

  // answer register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // channel parameter store
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < CHAN_COUNT * CHAN_SUBS; i++)
        chan_mem[i] <= CHAN_RESET;
    end
    else if (mem_we)
      chan_mem[addr] <= req.wdata;
  end

  assign rsp = s_q;

  fixed_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    req_valid && req.wr && req.index[15:12] == AREA_IDENT |=> rsp.ack && rsp.abort)
    else $error("write to a fixed entry was not refused");

endmodule : fbss_dict

// file: hdl/fbss_pdio.sv
// process data path: input copy and refresh, output gating and watchdog
`timescale 1ns/1ns
module fbss_pdio
  import fbss_pkg::*;
#(
  parameter int WDOG_CYCLES = WDOG_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control from the state machine and the watchdog disable input
  input wire logic copy_now,
  input wire logic refresh_en,
  input wire logic apply_out,
  input wire logic wdog_disable,
  // output process data from the master
  input wire logic pd_wr,
  input wire logic [15:0] pd_wr_data,
  // physical side
  input wire logic [15:0] phys_in,
  output logic [15:0] phys_out,
  output logic [15:0] pd_out,
  // input area of the dual-port memory, copy done and watchdog status
  output logic dpram_we,
  output logic [15:0] dpram_data,
  output logic copy_done,
  output logic wdog_expired
);

  fbss_pdio_type s_q;
  fbss_pdio_type s_d;

  // next state of the process data path
  always_comb
  begin
    s_d = s_q;
    s_d.dpram_we = 1'b0;
    if (pd_wr)
    begin
      s_d.pd_data = pd_wr_data;
      s_d.wd_cnt = 16'(WDOG_CYCLES - 1); // fresh data rearms the watchdog
    end
    else if (s_q.wd_cnt != 16'h0000)
      s_d.wd_cnt = s_q.wd_cnt - 16'h0001;
    // one snapshot of the inputs before the guarded state is acknowledged
    if (copy_now && !s_q.copied)
    begin
      s_d.dpram_we = 1'b1;
      s_d.dpram_data = phys_in;
      s_d.copied = 1'b1;
    end
    else if (!copy_now)
      s_d.copied = 1'b0;
    // cyclic input refresh
    if (refresh_en && !copy_now)
    begin
      if (s_q.ref_cnt == 16'h0000)
      begin
        s_d.ref_cnt = 16'(REFRESH_CYC - 1);
        s_d.dpram_we = 1'b1;
        s_d.dpram_data = phys_in;
      end
      else
        s_d.ref_cnt = s_q.ref_cnt - 16'h0001;
    end
    // outputs only follow data when allowed and the watchdog is disabled or has not run out
    if (apply_out && (wdog_disable || s_q.wd_cnt != 16'h0000))
      s_d.phys_out = s_q.pd_data;
    else
      s_d.phys_out = SAFE_OUT;
  end

  // state register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
      s_q.phys_out <= SAFE_OUT;
    end
    else
      s_q <= s_d;
  end

  assign phys_out = s_q.phys_out;
  assign pd_out = s_q.pd_data;
  assign dpram_we = s_q.dpram_we;
  assign dpram_data = s_q.dpram_data;
  assign copy_done = s_q.copied;
  assign wdog_expired = s_q.wd_cnt == 16'h0000;

  safe_outputs_a: assert property (@(posedge clk) disable iff (!arst_n)
    !apply_out |=> phys_out == SAFE_OUT)
    else $error("outputs left safe value while not allowed");

  watchdog_safe_a: assert property (@(posedge clk) disable iff (!arst_n)
    wdog_expired && !wdog_disable && !pd_wr |=> phys_out == SAFE_OUT)
    else $error("expired watchdog did not force safe outputs");

endmodule : fbss_pdio

// file: hdl/fbss_top.sv
// fieldbus slave state machine with traffic gating, process data and dictionary
`timescale 1ns/1ns
module fbss_top
  import fbss_pkg::*;
#(
  parameter int WDOG_CYCLES = WDOG_CYC
)
(
  // clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // state requests from the master
  input wire logic REQ_VALID,
  input wire logic [3:0] REQ_STATE,
  input wire logic ERR_ACK,
  // configuration checks
  input wire logic MBX_CFG_OK,
  input wire logic PD_CFG_OK,
  input wire logic DC_USED,
  input wire logic DC_CFG_OK,
  input wire logic WDOG_DISABLE,
  // mailbox traffic
  input wire logic MBX_VALID,
  input wire logic [3:0] MBX_PROTO,
  output logic MBX_ACCEPT,
  output logic MBX_REJECT,
  // process data traffic
  input wire logic PD_WR_VALID,
  input wire logic [15:0] PD_WR_DATA,
  output logic PD_WR_ACCEPT,
  input wire logic PD_RD_REQ,
  output logic PD_RD_ACCEPT,
  output logic DPRAM_IN_WE,
  output logic [15:0] DPRAM_IN_DATA,
  // dictionary access
  input wire logic DICT_REQ_VALID,
  input wire fbss_dict_req_type DICT_REQ,
  output fbss_dict_rsp_type DICT_RSP,
  // physical side
  input wire logic [15:0] PHYS_IN,
  output logic [15:0] PHYS_OUT,
  output logic WDOG_EXPIRED,
  // status to the master
  output logic [3:0] AL_STATE,
  output logic CHANGE_ACK,
  output logic ERR_IND
);

  fbss_top_type s_q;
  fbss_top_type s_d;
  logic bad;
  logic mbx_open;
  logic pd_open;
  logic dict_en;
  logic apply_out;
  logic copy_done;
  logic [15:0] pd_out;
  logic [3:0] cur_code;

  assign cur_code = fbss_code(s_q.st);

  // state transitions, checks and error flag
  always_comb
  begin
    s_d = s_q;
    s_d.ack = 1'b0;
    bad = 1'b0;
    if (ERR_ACK)
      s_d.err = 1'b0;
    if (s_q.st == FBSS_ENTER_GUARD)
    begin
      // requests are ignored until the input copy is done
      if (copy_done)
      begin
        s_d.st = FBSS_GUARD;
        s_d.ack = 1'b1;
      end
    end
    else if (REQ_VALID)
    begin
      if (REQ_STATE == cur_code)
        s_d.ack = 1'b1;
      else if (REQ_STATE == AL_INIT)
      begin
        s_d.st = FBSS_INIT;
        s_d.ack = 1'b1;
      end
      else
      begin
        unique case (s_q.st)
          FBSS_INIT:
          begin
            if (REQ_STATE == AL_PREP && MBX_CFG_OK)
            begin
              s_d.st = FBSS_PREP;
              s_d.ack = 1'b1;
            end
            else if (REQ_STATE == AL_UPDATE)
            begin
              s_d.st = FBSS_UPDATE;
              s_d.ack = 1'b1;
            end
            else
              bad = 1'b1;
          end
          FBSS_PREP:
          begin
            if (REQ_STATE == AL_GUARD && PD_CFG_OK && (!DC_USED || DC_CFG_OK))
              s_d.st = FBSS_ENTER_GUARD;
            else
              bad = 1'b1;
          end
          FBSS_GUARD:
          begin
            if (REQ_STATE == AL_RUN || REQ_STATE == AL_PREP)
            begin
              s_d.st = REQ_STATE == AL_RUN ? FBSS_RUN : FBSS_PREP;
              s_d.ack = 1'b1;
            end
            else
              bad = 1'b1;
          end
          FBSS_RUN:
          begin
            if (REQ_STATE == AL_GUARD || REQ_STATE == AL_PREP)
            begin
              s_d.st = REQ_STATE == AL_GUARD ? FBSS_GUARD : FBSS_PREP;
              s_d.ack = 1'b1;
            end
            else
              bad = 1'b1;
          end
          default:
            bad = 1'b1; // update leaves only towards init
        endcase
      end
    end
    // a new error wins over a clear in the same cycle
    if (bad)
      s_d.err = 1'b1;
  end

  // state register, init after reset
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      s_q.st <= FBSS_INIT;
      s_q.ack <= 1'b0;
      s_q.err <= 1'b0;
    end
    else
      s_q <= s_d;
  end

  // traffic gates per state
  assign mbx_open = s_q.st != FBSS_INIT;
  assign pd_open = s_q.st == FBSS_GUARD || s_q.st == FBSS_RUN;
  assign MBX_ACCEPT = MBX_VALID && mbx_open
    && (s_q.st != FBSS_UPDATE || MBX_PROTO == MBX_PROTO_FILE);
  assign MBX_REJECT = MBX_VALID && !MBX_ACCEPT;
  assign PD_WR_ACCEPT = PD_WR_VALID && pd_open;
  assign PD_RD_ACCEPT = PD_RD_REQ && pd_open;
  assign dict_en = mbx_open && s_q.st != FBSS_UPDATE;
  assign apply_out = s_q.st == FBSS_RUN
    || (s_q.st == FBSS_GUARD && WDOG_DISABLE);

  // status outputs
  assign AL_STATE = cur_code;
  assign CHANGE_ACK = s_q.ack;
  assign ERR_IND = s_q.err;

  // process data path
  fbss_pdio #(
    .WDOG_CYCLES(WDOG_CYCLES)
  ) u_pdio (
    .clk(MCLK),
    .arst_n(ARST_N),
    .copy_now(s_q.st == FBSS_ENTER_GUARD),
    .refresh_en(pd_open),
    .apply_out(apply_out),
    .wdog_disable(WDOG_DISABLE),
    .pd_wr(PD_WR_ACCEPT),
    .pd_wr_data(PD_WR_DATA),
    .phys_in(PHYS_IN),
    .phys_out(PHYS_OUT),
    .pd_out(pd_out),
    .dpram_we(DPRAM_IN_WE),
    .dpram_data(DPRAM_IN_DATA),
    .copy_done(copy_done),
    .wdog_expired(WDOG_EXPIRED)
  );

  // parameter dictionary
  fbss_dict u_dict (
    .clk(MCLK),
    .arst_n(ARST_N),
    .req_valid(DICT_REQ_VALID),
    .req(DICT_REQ),
    .enable(dict_en),
    .phys_in(PHYS_IN),
    .pd_out(pd_out),
    .rsp(DICT_RSP)
  );

  init_gate_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    s_q.st == FBSS_INIT |-> !MBX_ACCEPT && !PD_WR_ACCEPT && !PD_RD_ACCEPT)
    else $error("traffic accepted in init");

  prep_check_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    $past(s_q.st) == FBSS_INIT && s_q.st == FBSS_PREP |-> $past(MBX_CFG_OK))
    else $error("preparation entered without mailbox check");

  prep_gate_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    s_q.st == FBSS_PREP && MBX_VALID |-> MBX_ACCEPT && !PD_WR_ACCEPT && !PD_RD_ACCEPT)
    else $error("wrong traffic gating in preparation");

  guard_check_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    $past(s_q.st) == FBSS_PREP && s_q.st == FBSS_ENTER_GUARD
      |-> $past(PD_CFG_OK) && (!$past(DC_USED) || $past(DC_CFG_OK)))
    else $error("guarded entry without process data check");

  copy_before_ack_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    $rose(s_q.st == FBSS_ENTER_GUARD) |-> ##1 DPRAM_IN_WE ##1 CHANGE_ACK && AL_STATE == AL_GUARD)
    else $error("guarded acknowledged without input copy");

  guard_traffic_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    s_q.st == FBSS_GUARD && PD_WR_VALID && PD_RD_REQ |-> PD_WR_ACCEPT && PD_RD_ACCEPT)
    else $error("process data blocked in guarded");

  run_apply_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    s_q.st == FBSS_RUN && PD_WR_ACCEPT ##1 s_q.st == FBSS_RUN && !PD_WR_ACCEPT
      |=> PHYS_OUT == $past(PD_WR_DATA, 2))
    else $error("running did not apply output data");

  update_entry_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    s_q.st == FBSS_UPDATE && $past(s_q.st) != FBSS_UPDATE |-> $past(s_q.st) == FBSS_INIT)
    else $error("update entered from a state other than init");

  update_gate_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    s_q.st == FBSS_UPDATE |-> !PD_WR_ACCEPT && !PD_RD_ACCEPT
      && (!MBX_VALID || MBX_ACCEPT == (MBX_PROTO == MBX_PROTO_FILE)))
    else $error("wrong traffic gating in update");

  refused_hold_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    $rose(ERR_IND) |-> s_q.st == $past(s_q.st) && !CHANGE_ACK)
    else $error("refused transition changed the state");

endmodule : fbss_top

// file: shared/fbss_pkg.sv
// shared constants, state codes and carriers of the fieldbus slave state machine
package fbss_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int REFRESH_TIME_NS = 1000;
  localparam int REFRESH_CYC = REFRESH_TIME_NS / CLK_PERIOD_NS;
  localparam int WDOG_TIME_US = 100;
  localparam int WDOG_CYC = WDOG_TIME_US * 1000 / CLK_PERIOD_NS;

  // reported and requested state codes
  localparam logic [3:0] AL_INIT = 4'h1;
  localparam logic [3:0] AL_PREP = 4'h2;
  localparam logic [3:0] AL_UPDATE = 4'h3;
  localparam logic [3:0] AL_GUARD = 4'h4;
  localparam logic [3:0] AL_RUN = 4'h8;

  // mailbox protocol code of the file transfer protocol
  localparam logic [3:0] MBX_PROTO_FILE = 4'h4;

  // safe value of the physical outputs
  localparam logic [15:0] SAFE_OUT = 16'h0000;

  // dictionary areas, taken from index bits 15..12
  localparam logic [3:0] AREA_IDENT = 4'h1;
  localparam logic [3:0] AREA_LEGACY = 4'h4;
  localparam logic [3:0] AREA_IN = 4'h6;
  localparam logic [3:0] AREA_OUT = 4'h7;
  localparam logic [3:0] AREA_CHAN = 4'h8;
  localparam logic [15:0] DICT_INDEX_MAX = 16'hFFFF;
  localparam logic [7:0] DICT_SUB_MAX = 8'hFF;
  localparam logic [15:0] IDX_DEVTYPE = 16'h1000;
  localparam logic [15:0] IDX_IDENTITY = 16'h1018;
  localparam logic [15:0] IDENT_COUNT = 16'h0002;
  localparam logic [15:0] DEVTYPE_VAL = 16'h0000; // arbitrary value
  localparam logic [15:0] VENDOR_VAL = 16'h5A5A; // arbitrary value
  localparam logic [15:0] PRODUCT_VAL = 16'h0C3E; // arbitrary value
  localparam int CHAN_COUNT = 4;
  localparam int CHAN_SUBS = 16;
  localparam logic [15:0] CHAN_RESET = 16'h0000;

  typedef enum logic [2:0] {
    FBSS_INIT,
    FBSS_PREP,
    FBSS_ENTER_GUARD,
    FBSS_GUARD,
    FBSS_RUN,
    FBSS_UPDATE
  } fbss_state_type;

  typedef struct packed {
    fbss_state_type st;
    logic ack;
    logic err;
  } fbss_top_type;

  typedef struct packed {
    logic wr;
    logic [15:0] index;
    logic [7:0] sub;
    logic [15:0] wdata;
  } fbss_dict_req_type;

  typedef struct packed {
    logic ack;
    logic abort;
    logic [15:0] rdata;
  } fbss_dict_rsp_type;

  typedef struct packed {
    logic [15:0] phys_out;
    logic [15:0] pd_data;
    logic dpram_we;
    logic [15:0] dpram_data;
    logic copied;
    logic [15:0] wd_cnt;
    logic [15:0] ref_cnt;
  } fbss_pdio_type;

  // state code shown to the master; the input copy still counts as preparation
  function automatic logic [3:0] fbss_code(input fbss_state_type st);
    logic [3:0] c;
    c = AL_INIT;
    unique case (st)
      FBSS_INIT: c = AL_INIT;
      FBSS_PREP: c = AL_PREP;
      FBSS_ENTER_GUARD: c = AL_PREP;
      FBSS_GUARD: c = AL_GUARD;
      FBSS_RUN: c = AL_RUN;
      FBSS_UPDATE: c = AL_UPDATE;
      default: c = AL_INIT;
    endcase
    return c;
  endfunction : fbss_code

endpackage : fbss_pkg

// file: verification/fbss_master_model.sv
// model of the bus master: state requests, configuration results, output data
`timescale 1ns/1ns
module fbss_master_model
(
  // clock
  input wire logic clk,
  // state requests
  output logic req_valid,
  output logic [3:0] req_state,
  // configuration results
  output logic mbx_cfg_ok,
  output logic pd_cfg_ok,
  output logic dc_used,
  output logic dc_cfg_ok,
  // output process data
  output logic pd_wr_valid,
  output logic [15:0] pd_wr_data
);
  // idle at time zero, nothing configured yet
  initial
  begin
    req_valid = 1'b0;
    req_state = 4'h0;
    {mbx_cfg_ok, pd_cfg_ok, dc_used, dc_cfg_ok} = 4'h0;
    pd_wr_valid = 1'b0;
    pd_wr_data = 16'h0000;
  end

  // mailbox check in bit 3, process data check in bit 2, clock use and clock check in bits 1 and 0
  task automatic set_cfg(input logic [3:0] c);
    @(posedge clk);
    {mbx_cfg_ok, pd_cfg_ok, dc_used, dc_cfg_ok} <= c;
  endtask : set_cfg

  // one-cycle state request, code scrambled once released
  task automatic request(input logic [3:0] s);
    @(posedge clk);
    req_valid <= 1'b1;
    req_state <= s;
    @(posedge clk);
    req_valid <= 1'b0;
    req_state <= ~s;
  endtask : request

  // one-cycle output data write, data scrambled once released
  task automatic write_pd(input logic [15:0] d);
    @(posedge clk);
    pd_wr_valid <= 1'b1;
    pd_wr_data <= d;
    @(posedge clk);
    pd_wr_valid <= 1'b0;
    pd_wr_data <= ~d;
  endtask : write_pd
endmodule : fbss_master_model

// file: verification/tb_top.sv
// self-checking bench of the fieldbus slave state machine
`timescale 1ns/1ns
module tb_top
  import fbss_pkg::*;
;
  localparam logic [15:0] PIN = 16'hA5C3;
  // bench-driven inputs
  logic MCLK = 1'b0, ARST_N = 1'b0, ERR_ACK = 1'b0, WDOG_DISABLE = 1'b0;
  logic MBX_VALID = 1'b0, PD_RD_REQ = 1'b0, DICT_REQ_VALID = 1'b0;
  logic [3:0] MBX_PROTO = 4'h0;
  logic [15:0] PHYS_IN = PIN;
  fbss_dict_req_type DICT_REQ = '0;
  // master-driven inputs
  logic REQ_VALID, MBX_CFG_OK, PD_CFG_OK, DC_USED, DC_CFG_OK, PD_WR_VALID;
  logic [3:0] REQ_STATE;
  logic [15:0] PD_WR_DATA;
  // outputs
  logic MBX_ACCEPT, MBX_REJECT, PD_WR_ACCEPT, PD_RD_ACCEPT, DPRAM_IN_WE;
  logic WDOG_EXPIRED, CHANGE_ACK, ERR_IND;
  logic [15:0] DPRAM_IN_DATA, PHYS_OUT;
  logic [3:0] AL_STATE;
  fbss_dict_rsp_type DICT_RSP;
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;

  // design with a short watchdog
  fbss_top #(.WDOG_CYCLES(20)) i_fbss_top (.MCLK, .ARST_N, .REQ_VALID, .REQ_STATE,
    .ERR_ACK, .MBX_CFG_OK, .PD_CFG_OK, .DC_USED, .DC_CFG_OK, .WDOG_DISABLE, .MBX_VALID,
    .MBX_PROTO, .MBX_ACCEPT, .MBX_REJECT, .PD_WR_VALID, .PD_WR_DATA, .PD_WR_ACCEPT,
    .PD_RD_REQ, .PD_RD_ACCEPT, .DPRAM_IN_WE, .DPRAM_IN_DATA, .DICT_REQ_VALID, .DICT_REQ,
    .DICT_RSP, .PHYS_IN, .PHYS_OUT, .WDOG_EXPIRED, .AL_STATE, .CHANGE_ACK, .ERR_IND);

  // bus master partner
  fbss_master_model u_master (.clk(MCLK), .req_valid(REQ_VALID), .req_state(REQ_STATE),
    .mbx_cfg_ok(MBX_CFG_OK), .pd_cfg_ok(PD_CFG_OK), .dc_used(DC_USED),
    .dc_cfg_ok(DC_CFG_OK), .pd_wr_valid(PD_WR_VALID), .pd_wr_data(PD_WR_DATA));

  // 125 MHz clock
  always #4 MCLK = ~MCLK;

  // hang guard
  always @(posedge MCLK)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: timeout", $time);
      stop_test();
    end
  end

  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  // one comparison
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk

  // offer mailbox and input read for one cycle
  task automatic gate(input logic [3:0] proto, input logic mbx, input logic pd);
    @(posedge MCLK);
    MBX_VALID <= 1'b1;
    MBX_PROTO <= proto;
    PD_RD_REQ <= 1'b1;
    #1;
    chk(MBX_ACCEPT === mbx && MBX_REJECT === !mbx, "mailbox gate");
    chk(PD_RD_ACCEPT === pd && PD_WR_ACCEPT === (pd && PD_WR_VALID), "process data gate");
    @(posedge MCLK);
    MBX_VALID <= 1'b0;
    PD_RD_REQ <= 1'b0;
  endtask : gate

  // request a state and judge the one-cycle answer, clearing any error
  task automatic step(input logic [3:0] s, input logic [3:0] st, input logic ok);
    u_master.request(s);
    #1;
    chk(AL_STATE === st, "state code");
    chk(CHANGE_ACK === ok && ERR_IND === !ok, "ack or error");
    if (!ok)
    begin
      @(posedge MCLK);
      ERR_ACK <= 1'b1;
      @(posedge MCLK);
      ERR_ACK <= 1'b0;
      #1;
      chk(ERR_IND === 1'b0, "error cleared");
    end
  endtask : step

  // one dictionary access
  task automatic dict(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
    input logic [15:0] wd, input logic ab, input logic [15:0] exp);
    @(posedge MCLK);
    DICT_REQ_VALID <= 1'b1;
    DICT_REQ <= {wr, idx, sub, wd};
    @(posedge MCLK);
    DICT_REQ_VALID <= 1'b0;
    #1;
    chk(DICT_RSP.ack === 1'b1 && DICT_RSP.abort === ab, "dictionary answer");
    if (!ab)
      chk(DICT_RSP.rdata === exp, "dictionary data");
  endtask : dict

  task automatic test_reset;
    @(posedge MCLK);
    #1;
    chk(AL_STATE === AL_INIT && PHYS_OUT === SAFE_OUT, "reset state");
    fork
      gate(MBX_PROTO_FILE, 1'b0, 1'b0);
      u_master.write_pd(16'hFFFF);
    join
    dict(1'b0, IDX_IDENTITY, 8'h01, 16'h0000, 1'b1, 16'h0000);
    step(AL_RUN, AL_INIT, 1'b0);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_prep;
    step(AL_PREP, AL_INIT, 1'b0);
    u_master.set_cfg(4'h8);
    step(AL_PREP, AL_PREP, 1'b1);
    fork
      gate(4'h1, 1'b1, 1'b0);
      u_master.write_pd(16'hFFFF);
    join
    step(AL_UPDATE, AL_PREP, 1'b0);
    $display("test_prep done");
  endtask : test_prep

  task automatic test_dict;
    dict(1'b1, 16'h8010, 8'h03, 16'hBEEF, 1'b0, 16'hBEEF);
    dict(1'b0, 16'h4010, 8'h03, 16'h0000, 1'b0, 16'hBEEF);
    dict(1'b1, 16'h4030, 8'h0F, 16'h0F0F, 1'b0, 16'h0F0F);
    dict(1'b0, 16'h8030, 8'h0F, 16'h0000, 1'b0, 16'h0F0F);
    dict(1'b0, IDX_IDENTITY, 8'h01, 16'h0000, 1'b0, VENDOR_VAL);
    dict(1'b1, IDX_DEVTYPE, 8'h00, 16'h1111, 1'b1, 16'h0000);
    dict(1'b0, 16'h6000, 8'h01, 16'h0000, 1'b0, PIN);
    dict(1'b0, DICT_INDEX_MAX, DICT_SUB_MAX, 16'h0000, 1'b1, 16'h0000);
    $display("test_dict done");
  endtask : test_dict

  task automatic test_guard;
    u_master.set_cfg(4'hE);
    step(AL_GUARD, AL_PREP, 1'b0);
    u_master.set_cfg(4'hF);
    PHYS_IN <= ~PIN;
    u_master.request(AL_GUARD);
    for (int i = 0; i < 8 && DPRAM_IN_WE !== 1'b1; i++)
    begin
      @(posedge MCLK);
      #1;
    end
    chk(DPRAM_IN_DATA === ~PIN && CHANGE_ACK === 1'b0, "input copy");
    @(posedge MCLK);
    #1;
    chk(CHANGE_ACK === 1'b1 && AL_STATE === AL_GUARD, "guard entry");
    fork
      gate(4'h1, 1'b1, 1'b1);
      u_master.write_pd(16'h00FF);
    join
    WDOG_DISABLE <= 1'b1;
    repeat (3) @(posedge MCLK);
    #1;
    chk(PHYS_OUT === 16'h00FF, "guard outputs unlocked");
    @(posedge MCLK);
    WDOG_DISABLE <= 1'b0;
    repeat (3) @(posedge MCLK);
    #1;
    chk(PHYS_OUT === SAFE_OUT, "guard outputs safe");
    $display("test_guard done");
  endtask : test_guard

  task automatic test_run;
    u_master.write_pd(16'h1234);
    step(AL_RUN, AL_RUN, 1'b1);
    repeat (2) @(posedge MCLK);
    #1;
    chk(PHYS_OUT === 16'h1234, "outputs applied");
    fork
      gate(4'h2, 1'b1, 1'b1);
      u_master.write_pd(16'h4321);
    join
    repeat (2) @(posedge MCLK);
    #1;
    chk(PHYS_OUT === 16'h4321, "new outputs applied");
    repeat (30) @(posedge MCLK);
    #1;
    chk(PHYS_OUT === SAFE_OUT && WDOG_EXPIRED === 1'b1, "watchdog");
    $display("test_run done");
  endtask : test_run

  task automatic test_update;
    step(AL_INIT, AL_INIT, 1'b1);
    step(AL_UPDATE, AL_UPDATE, 1'b1);
    fork
      gate(MBX_PROTO_FILE, 1'b1, 1'b0);
      u_master.write_pd(16'hFFFF);
    join
    dict(1'b0, IDX_IDENTITY, 8'h01, 16'h0000, 1'b1, 16'h0000);
    gate(4'h3, 1'b0, 1'b0);
    $display("test_update done");
  endtask : test_update

  // main sequence
  initial
  begin
    repeat (6) @(posedge MCLK);
    ARST_N <= 1'b1;
    test_reset();
    test_prep();
    test_dict();
    test_guard();
    test_run();
    test_update();
    stop_test();
  end
endmodule : tb_top
